// file: logic/mds_pkg.sv
// Package with register map, field layout and types of the motor driver status block.
package mds_pkg;
  localparam int          ADDR_W        = 9;
  localparam logic [7:0]  STATUS_IDX    = 8'h6F;
  localparam logic [8:0]  STATUS_ADDR   = {STATUS_IDX, 1'b0} << 1;
  localparam logic [8:0]  CTRL_ADDR     = 9'h000;
  localparam logic [8:0]  IRQ_STS_ADDR  = 9'h004;
  localparam logic [8:0]  IRQ_MSK_ADDR  = 9'h008;
  localparam int          STST_BIT      = 31;
  localparam int          CHOP_BIT      = 30;
  localparam int          CS_LSB        = 16;
  localparam int          CS_MSB        = 20;
  localparam int          TEMP_LSB      = 8;
  localparam int          OPEN_LSB      = 6;
  localparam int          SHORT_LSB     = 2;
  localparam int          OT_BIT        = 1;
  localparam int          PREWARN_BIT   = 0;
  localparam int          STST_CYCLES   = 1048576;
  localparam int          IDLE_W        = 21;
  localparam logic [7:0]  CTRL_RESET    = 8'h03;
  localparam logic [2:0]  IRQ_MSK_RESET = 3'h0;
  localparam int          EVT_SHORT     = 0;
  localparam int          EVT_OT        = 1;
  localparam int          EVT_STST      = 2;

  // Control word: off-time setting, chopper choice and overtemperature limit choice.
  typedef struct packed {
    logic [0:0] ot_sel_hi;
    logic [1:0] ot_sel;
    logic       quiet_chop;
    logic [3:0] offtime_setting;
  } mds_ctrl_t;

  // Analog front-end indications; shorts are in order b low-side, a low-side, b ground, a ground.
  typedef struct packed {
    logic [4:0] cs_actual;
    logic [3:0] temp_cmp;
    logic [1:0] open_load;
    logic [3:0] short_evt;
  } mds_sense_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;
    logic [31:0] writedata;
  } mds_avs_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [20:0] idle_cnt;
    logic        stst;
    logic [3:0]  short_quiet;
    logic [3:0]  short_cycle;
    logic        ot;
    mds_ctrl_t   ctrl;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_msk;
    logic        irq;
    logic        bridge_en;
  } mds_state_t;
endpackage

// file: logic/mds_status.sv
// Driver status word, short and overtemperature protection, and its register slave.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE1] Status word sits at index 0x6F and reads back flags and current level.
// [RULE2] Bit 31 sets once 2^20 clocks pass after the latest step pulse.
// [RULE3] Bit 30 is one for the quiet voltage chopper, zero for the cycle chopper.
// [RULE4] Bits 20 to 16 show the actual current scaling value.
// [RULE5] Bits 11 to 8 show the 157, 150, 143 and 120 degree comparators.
// [RULE6] Bits 7 and 6 show open load on B and A and cause no action.
// [RULE7] Software reads the open-load bits only during slow motion.
// [RULE8] A low-side short sets bit 5 or 4 and switches the bridges off.
// [RULE9] A short to ground sets bit 3 or 2 and switches the bridges off.
// [RULE10] Short bits hold until off-time zero or the enable pin disables the driver.
// [RULE11] Each chopper mode keeps its own set of short bits.
// [RULE12] Bit 1 sets at the chosen limit; bridges stay off until prewarning clears.
// [RULE13] One overtemperature bit covers both bridges.
// [RULE14] Bit 0 is the prewarning level, below the overtemperature limit.
module mds_status
  import mds_pkg::*;
#(
  parameter int STST_CNT = STST_CYCLES
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire mds_avs_req_t avs_req,
  output var  logic         avs_waitrequest,
  output var  logic [31:0]  avs_readdata,
  input  wire logic         step_pulse,
  input  wire logic         driver_enable_low,
  input  wire mds_sense_t   sense,
  output var  logic         bridge_enable,
  output var  logic         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and decode helpers.

  logic [1:0] rst_sync;
  wire        rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  function automatic logic addr_hit(input logic [8:0] a, input logic [8:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  // Selected overtemperature comparator: 0 picks 143, 1 picks 150, else 157.
  function automatic logic ot_limit(input logic [1:0] sel, input logic [3:0] cmp);
    case (sel)
      2'h0:    ot_limit = cmp[1];
      2'h1:    ot_limit = cmp[2];
      default: ot_limit = cmp[3];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State update.

  mds_state_t st;
  mds_state_t next_st;
  logic [3:0] act_short;
  logic       drv_off;
  logic [2:0] evt;
  logic [31:0] status_word;

  always_comb begin
    act_short = st.ctrl.quiet_chop ? st.short_quiet : st.short_cycle; // [RULE11]
    drv_off   = (st.ctrl.offtime_setting == 4'h0) || driver_enable_low;

    status_word                               = 32'h0000_0000; // [RULE1]
    status_word[STST_BIT]                     = st.stst; // [RULE2]
    status_word[CHOP_BIT]                     = st.ctrl.quiet_chop; // [RULE3]
    status_word[CS_MSB:CS_LSB]                = sense.cs_actual; // [RULE4]
    status_word[TEMP_LSB+3:TEMP_LSB]          = sense.temp_cmp; // [RULE5]
    status_word[OPEN_LSB+1:OPEN_LSB]          = sense.open_load; // [RULE6]
    status_word[SHORT_LSB+3:SHORT_LSB]        = act_short; // [RULE8] [RULE9]
    status_word[OT_BIT]                       = st.ot; // [RULE13]
    status_word[PREWARN_BIT]                  = sense.temp_cmp[0]; // [RULE14]

    next_st = st;

    // The idle count saturates so a long pause cannot wrap and clear standstill.
    if (step_pulse) begin
      next_st.idle_cnt = '0; // [RULE2]
    end else if (st.idle_cnt != IDLE_W'(STST_CNT)) begin
      next_st.idle_cnt = st.idle_cnt + 21'h00_0001;
    end
    next_st.stst = (next_st.idle_cnt == IDLE_W'(STST_CNT)); // [RULE2]

    // A short reported in the same cycle as a disable still latches.
    if (drv_off) begin
      next_st.short_quiet = 4'h0; // [RULE10]
      next_st.short_cycle = 4'h0; // [RULE10]
    end
    if (st.ctrl.quiet_chop) begin
      next_st.short_quiet = next_st.short_quiet | sense.short_evt; // [RULE8] [RULE9] [RULE11]
    end else begin
      next_st.short_cycle = next_st.short_cycle | sense.short_evt; // [RULE8] [RULE9] [RULE11]
    end

    // Overheat holds until both the limit and the prewarning comparator drop.
    if (ot_limit(st.ctrl.ot_sel, sense.temp_cmp)) begin
      next_st.ot = 1'b1; // [RULE12] [RULE13]
    end else if (!sense.temp_cmp[0]) begin
      next_st.ot = 1'b0; // [RULE12]
    end

    // Open load is deliberately absent here: it is an indication only.
    next_st.bridge_en = !st.ot && (act_short == 4'h0) && !drv_off; // [RULE8] [RULE9] [RULE12]

    evt[EVT_SHORT] = |sense.short_evt;
    evt[EVT_OT]    = next_st.ot && !st.ot;
    evt[EVT_STST]  = next_st.stst && !st.stst;

    // Single wait state: the request is answered on the edge after it appears.
    next_st.ack = (avs_req.read || avs_req.write) && !st.ack;
    if (next_st.ack && avs_req.read) begin
      if (addr_hit(avs_req.address, STATUS_ADDR)) begin
        next_st.rdata = status_word; // [RULE1]
      end else if (addr_hit(avs_req.address, CTRL_ADDR)) begin
        next_st.rdata = {24'h00_0000, st.ctrl};
      end else if (addr_hit(avs_req.address, IRQ_STS_ADDR)) begin
        next_st.rdata = {29'h0, st.irq_sts};
      end else if (addr_hit(avs_req.address, IRQ_MSK_ADDR)) begin
        next_st.rdata = {29'h0, st.irq_msk};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    if (st.ack && avs_req.write) begin
      if (addr_hit(avs_req.address, CTRL_ADDR)) begin
        next_st.ctrl = mds_ctrl_t'(avs_req.writedata[7:0]);
      end
      if (addr_hit(avs_req.address, IRQ_MSK_ADDR)) begin
        next_st.irq_msk = avs_req.writedata[2:0];
      end
      if (addr_hit(avs_req.address, IRQ_STS_ADDR)) begin
        next_st.irq_sts = st.irq_sts & ~avs_req.writedata[2:0];
      end
    end
    next_st.irq_sts = next_st.irq_sts | evt;
    next_st.irq     = |(next_st.irq_sts & next_st.irq_msk);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.ctrl      <= mds_ctrl_t'(CTRL_RESET);
      st.irq_msk   <= IRQ_MSK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest = !st.ack;
  assign avs_readdata    = st.rdata;
  assign bridge_enable   = st.bridge_en;
  assign irq             = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  stst_after_idle_a: assert property ( // [RULE2]
    (st.idle_cnt == IDLE_W'(STST_CNT - 1) && !step_pulse) |=> st.stst && $rose(st.stst))
    else $error("standstill missing after idle count");

  stst_step_clear_a: assert property ( // [RULE2]
    step_pulse |=> !st.stst ##0 (st.idle_cnt == '0))
    else $error("standstill not cleared by step");

  status_read_a: assert property ( // [RULE1]
    (avs_req.read && st.ack && avs_req.address == STATUS_ADDR)
      |-> ##1 (avs_readdata[CHOP_BIT] == $past(st.ctrl.quiet_chop, 2))
           && (avs_readdata[29:21] == 9'h000) && (avs_readdata[OT_BIT] == $past(st.ot, 2)))
    else $error("status word read back wrong");

  short_latch_a: assert property ( // [RULE8]
    (sense.short_evt[3] && st.ctrl.quiet_chop) |=> st.short_quiet[3] ##1 !st.bridge_en)
    else $error("low-side short not latched or bridge on");

  short_hold_a: assert property ( // [RULE10]
    (st.short_cycle[0] && !drv_off) |=> st.short_cycle[0])
    else $error("short flag dropped while driver enabled");

  short_mode_a: assert property ( // [RULE11]
    (sense.short_evt[1] && !st.ctrl.quiet_chop && !st.short_quiet[1] && !drv_off) |=> !st.short_quiet[1])
    else $error("short crossed into other chopper set");

  ot_hold_a: assert property ( // [RULE12]
    (st.ot && sense.temp_cmp[0]) |=> st.ot ##1 !st.bridge_en)
    else $error("overheat released before prewarning cleared");

  irq_level_a: assert property (
    st.irq == |(st.irq_sts & st.irq_msk))
    else $error("interrupt output not matching status and mask");

  bus_answer_a: assert property (
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  wait_idle_a: assert property (
    !(avs_req.read || avs_req.write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  // Read data must stay put between reads so a slow master still sees its word.
  rdata_hold_a: assert property ( // [RULE1]
    !(avs_req.read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  ctrl_write_a: assert property (
    (avs_req.write && st.ack && avs_req.address == CTRL_ADDR) |=> (st.ctrl == $past(avs_req.writedata[7:0])))
    else $error("control write not taken");

  msk_write_a: assert property (
    (avs_req.write && st.ack && avs_req.address == IRQ_MSK_ADDR) |=> (st.irq_msk == $past(avs_req.writedata[2:0])))
    else $error("mask write not taken");

  // The status word is read only; a write there must leave the control word alone.
  status_ro_a: assert property ( // [RULE1]
    (avs_req.write && st.ack && avs_req.address == STATUS_ADDR) |=> $stable(st.ctrl))
    else $error("write to status word changed control");

  ////////////////////////////////////////////////////////////////////////////
  // Standstill checks.

  stst_hold_a: assert property ( // [RULE2]
    (st.stst && !step_pulse) |=> st.stst)
    else $error("standstill dropped without a step");

  stst_low_early_a: assert property ( // [RULE2]
    (st.idle_cnt < IDLE_W'(STST_CNT)) |-> !st.stst)
    else $error("standstill set before the idle count ran out");

  ////////////////////////////////////////////////////////////////////////////
  // Protection checks.

  // Each cause of a disable must pull the bridges off on its own.
  bridge_offtime_a: assert property ( // [RULE10]
    (st.ctrl.offtime_setting == 4'h0) |=> !st.bridge_en)
    else $error("bridge on with zero off-time");

  bridge_pin_a: assert property ( // [RULE10]
    driver_enable_low |=> !st.bridge_en)
    else $error("bridge on with enable pin high");

  bridge_short_a: assert property ( // [RULE8] [RULE9]
    (act_short != 4'h0) |=> !st.bridge_en)
    else $error("bridge on with short latched");

  bridge_ot_a: assert property ( // [RULE12]
    st.ot |=> !st.bridge_en)
    else $error("bridge on while overheated");

  // Open load is not a cause, so without a real cause the bridges must come on.
  open_load_free_a: assert property ( // [RULE6]
    (!st.ot && (act_short == 4'h0) && !drv_off) |=> st.bridge_en)
    else $error("bridge held off without a protection cause");

  ground_a_latch_a: assert property ( // [RULE9]
    (sense.short_evt[0] && !st.ctrl.quiet_chop) |=> st.short_cycle[0])
    else $error("ground short on phase A not latched");

  lowside_a_latch_a: assert property ( // [RULE8]
    (sense.short_evt[2] && !st.ctrl.quiet_chop) |=> st.short_cycle[2])
    else $error("low-side short on phase A not latched");

  short_clear_a: assert property ( // [RULE10]
    (drv_off && sense.short_evt == 4'h0) |=> (st.short_quiet == 4'h0) && (st.short_cycle == 4'h0))
    else $error("short flags kept while driver disabled");

  // Both short sets hold bit by bit while the driver stays enabled.
  for (genvar i = 0; i < 4; i++) begin : g_short_quiet_chk
    quiet_bit_hold_a: assert property ( // [RULE10] [RULE11]
      (st.short_quiet[i] && !drv_off) |=> st.short_quiet[i])
      else $error("quiet-mode short flag dropped while enabled");
  end

  for (genvar i = 0; i < 4; i++) begin : g_short_cycle_chk
    cycle_bit_hold_a: assert property ( // [RULE10] [RULE11]
      (st.short_cycle[i] && !drv_off) |=> st.short_cycle[i])
      else $error("cycle-mode short flag dropped while enabled");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature checks.

  ot_sel_143_a: assert property ( // [RULE12]
    (st.ctrl.ot_sel == 2'h0 && sense.temp_cmp[1]) |=> st.ot)
    else $error("overheat missed at lowest limit");

  ot_sel_150_a: assert property ( // [RULE12]
    (st.ctrl.ot_sel == 2'h1 && !sense.temp_cmp[2] && !st.ot) |=> !st.ot)
    else $error("overheat set below chosen limit");

  ot_sel_157_a: assert property ( // [RULE12]
    (st.ctrl.ot_sel == 2'h2 && sense.temp_cmp[3]) |=> st.ot)
    else $error("overheat missed at highest limit");

  // The prewarning level alone must never switch the bridges off.
  prewarn_only_a: assert property ( // [RULE14]
    (sense.temp_cmp == 4'h1 && !st.ot) |=> !st.ot)
    else $error("prewarning alone set overheat");

  ot_release_a: assert property ( // [RULE12] [RULE14]
    (sense.temp_cmp == 4'h0) |=> !st.ot)
    else $error("overheat kept after cooling");

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt checks.

  irq_set_wins_a: assert property (
    (|sense.short_evt) |=> st.irq_sts[EVT_SHORT])
    else $error("short event lost from interrupt status");

  ot_event_irq_a: assert property (
    $rose(st.ot) |-> st.irq_sts[EVT_OT])
    else $error("overheat rise not recorded");

  // Writing ones clears the status only when no new event arrives in that cycle.
  irq_clear_a: assert property (
    (avs_req.write && st.ack && avs_req.address == IRQ_STS_ADDR && avs_req.writedata[2:0] == 3'h7
      && evt == 3'h0) |=> (st.irq_sts == 3'h0))
    else $error("interrupt status not cleared by write");

  cover_short_c: cover property (st.short_cycle[2] ##[1:20] !st.short_cycle[2]);
  cover_ot_c:    cover property ($rose(st.ot) ##[1:50] $fell(st.ot));
  cover_irq_c:   cover property ($rose(irq));
  cover_read_c:  cover property (avs_req.read && st.ack && avs_req.address == STATUS_ADDR);
  cover_stst_c:  cover property ($rose(st.stst));

endmodule

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the driver status block, driven over its register bus.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mds_pkg::*;
;
  localparam logic [31:0] MSK = 32'hC01F0FFF;
  logic         clk    = 1'h0;
  logic         arst_n = 1'h0;
  mds_avs_req_t req    = '0;
  mds_sense_t   sn     = '0;
  logic         step   = 1'h0;
  logic         en_n   = 1'h0;
  logic [31:0]  rd;
  logic [3:0]   tv [4] = '{4'h1, 4'hF, 4'h1, 4'h0};
  logic [3:0]   otv    = 4'h6;
  int           failures        = 0;
  int           samples_checked = 0;
  wire logic        wreq;
  wire logic [31:0] rdat;
  wire logic        br;
  wire logic        irq;

  initial begin
    forever #4 clk = ~clk;
  end

  // A short standstill count keeps the run brief; expectations use the same value.
  mds_status #(.STST_CNT(16)) dut (.clk(clk), .arst_n(arst_n), .avs_req(req), .avs_waitrequest(wreq),
    .avs_readdata(rdat), .step_pulse(step), .driver_enable_low(en_n), .sense(sn), .bridge_enable(br), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The idle edge after release keeps two requests from being driven in one time step.
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    req <= {~w, w, a, d};
    do @(posedge clk); while (wreq !== 1'h0);
    rd = rdat;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic rs(input string nm, input logic [31:0] exp);
    bus(1'h0, STATUS_ADDR, 32'h0);
    chk(nm, rd & MSK, exp);
  endtask

  function automatic logic [31:0] st(input logic s, input logic c, input logic [3:0] sh, input logic o);
    return {s, c, 9'h0, sn.cs_actual, 4'h0, sn.temp_cmp, sn.open_load, sh, o, sn.temp_cmp[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    cyc(10);
    arst_n <= 1'h1;
    sn     <= {5'h15, 4'h0, 2'h2, 4'h0};
    cyc(24);
    rs("status idle", st(1'h1, 1'h0, 4'h0, 1'h0));
    chk("bridge open load", br, 32'h1);
    step <= 1'h1;
    @(posedge clk);
    step <= 1'h0;
    bus(1'h0, STATUS_ADDR, 32'h0);
    chk("standstill early", rd[STST_BIT], 32'h0);
    chk("open load slow", rd[7:6], 32'h2);
    cyc(16);
    bus(1'h0, STATUS_ADDR, 32'h0);
    chk("standstill late", rd[STST_BIT], 32'h1);
    for (int i = 0; i < 4; i++) begin
      sn.temp_cmp <= tv[i];
      cyc(3);
      rs("status temp", st(1'h1, 1'h0, 4'h0, otv[i]));
      chk("bridge temp", br, {31'h0, ~otv[i]});
    end
    bus(1'h1, CTRL_ADDR, 32'h23);
    sn.temp_cmp <= 4'h3;
    cyc(3);
    rs("status limit 150 below", st(1'h1, 1'h0, 4'h0, 1'h0));
    sn.temp_cmp <= 4'h7;
    cyc(3);
    rs("status limit 150 reached", st(1'h1, 1'h0, 4'h0, 1'h1));
    sn.temp_cmp <= 4'h0;
    cyc(3);
    bus(1'h1, CTRL_ADDR, 32'h13);
    rs("status quiet", st(1'h1, 1'h1, 4'h0, 1'h0));
    bus(1'h1, CTRL_ADDR, 32'h03);
    sn.short_evt <= 4'h1;
    @(posedge clk);
    sn.short_evt <= 4'h0;
    cyc(2);
    chk("bridge ground short", br, 32'h0);
    rs("status ground short", st(1'h1, 1'h0, 4'h1, 1'h0));
    bus(1'h1, CTRL_ADDR, 32'h13);
    rs("status other mode", st(1'h1, 1'h1, 4'h0, 1'h0));
    bus(1'h1, CTRL_ADDR, 32'h03);
    sn.short_evt <= 4'h8;
    @(posedge clk);
    sn.short_evt <= 4'h0;
    rs("status lowside", st(1'h1, 1'h0, 4'h9, 1'h0));
    bus(1'h1, CTRL_ADDR, 32'h00);
    bus(1'h1, CTRL_ADDR, 32'h03);
    rs("status offtime clear", st(1'h1, 1'h0, 4'h0, 1'h0));
    sn.short_evt <= 4'h2;
    @(posedge clk);
    sn.short_evt <= 4'h0;
    en_n <= 1'h1;
    cyc(3);
    chk("bridge pin off", br, 32'h0);
    en_n <= 1'h0;
    cyc(3);
    rs("status pin clear", st(1'h1, 1'h0, 4'h0, 1'h0));
    bus(1'h0, IRQ_STS_ADDR, 32'h0);
    chk("irq status", rd, 32'h7);
    chk("irq masked", irq, 32'h0);
    bus(1'h1, IRQ_MSK_ADDR, 32'h1);
    cyc(1);
    chk("irq raised", irq, 32'h1);
    bus(1'h1, IRQ_STS_ADDR, 32'h7);
    cyc(1);
    chk("irq cleared", irq, 32'h0);
    bus(1'h0, 9'h0FC, 32'h0);
    chk("unmapped read", rd, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
